// *** rtl/pct_pkg.sv ***
// package for the pin connectivity xor test block
package pct_pkg;

	typedef enum logic [1:0] {
		ORG_X4 = 2'b00,
		ORG_X8 = 2'b01,
		ORG_X16 = 2'b10
	} pct_org_t;

	typedef enum logic {
		MODE_NORMAL = 1'b0,
		MODE_CHECK = 1'b1
	} pct_mode_t;

	// test input pins as seen in check mode
	typedef struct packed {
		logic test_enable_pin;
		logic cs_n;
		logic [17:0] addr;
		logic [1:0] bank_sel;
		logic [1:0] group_sel;
		logic clock_true_pin;
		logic clock_comp_pin;
		logic cke;
		logic activate_cmd_pin;
		logic termination_control_pin;
		logic ca_parity_input;
		logic mask_inversion_pin_l;
		logic mask_inversion_pin_u;
		logic alert_n;
		logic mem_reset_pin_n;
	} pct_pins_t;

	// test output values; strobe order {comp upper, true upper, comp lower, true lower}
	typedef struct packed {
		logic [15:0] dq;
		logic [3:0] dqs;
	} pct_out_t;

	localparam pct_pins_t PCT_PINS_RST = '0;
	localparam pct_out_t PCT_OUT_RST = '0;
	localparam logic [15:0] PCT_DQ_OE_OFF = 16'hffff;
	localparam logic [3:0] PCT_DQS_OE_OFF = 4'hf;
	localparam logic [15:0] PCT_DQ_LANES_X4 = 16'h000f;
	localparam logic [15:0] PCT_DQ_LANES_X8 = 16'h00ff;
	localparam logic [15:0] PCT_DQ_LANES_X16 = 16'hffff;
	localparam logic [3:0] PCT_DQS_LANES_NARROW = 4'h3;
	localparam logic [3:0] PCT_DQS_LANES_X16 = 4'hf;
	// pin edge to output edge, in clock cycles
	localparam int PCT_OUT_LATENCY = 5;

endpackage : pct_pkg

// *** rtl/pct_xor_net.sv ***
// stateless xor network from test inputs to test outputs
`timescale 1ns/100ps
module pct_xor_net
	import pct_pkg::*;
#(
	parameter pct_org_t ORG = ORG_X8,
	parameter logic HAS_ADDR17 = 1'b1
) (
	input wire pct_pins_t pins,
	output pct_out_t outs
);

	function automatic logic xor3(input logic a, input logic b, input logic c);
		return a ^ b ^ c;
	endfunction : xor3

	logic [9:0] minterm;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		minterm[0] = xor3(pins.addr[1], pins.addr[6], pins.ca_parity_input);
		minterm[1] = xor3(pins.addr[8], pins.alert_n, pins.addr[9]);
		minterm[2] = xor3(pins.addr[2], pins.addr[5], pins.addr[13])
			^ (HAS_ADDR17 & pins.addr[17]);
		minterm[3] = xor3(pins.addr[0], pins.addr[7], pins.addr[11]);
		minterm[4] = xor3(pins.clock_comp_pin, pins.termination_control_pin,
			pins.addr[15]);
		minterm[5] = xor3(pins.cke, pins.addr[16], pins.addr[10]);
		minterm[6] = xor3(pins.activate_cmd_pin, pins.addr[4], pins.bank_sel[1]);
		case (ORG)
			ORG_X16: minterm[7] = xor3(pins.mask_inversion_pin_u,
				pins.mask_inversion_pin_l, pins.clock_true_pin);
			ORG_X8: minterm[7] = xor3(pins.group_sel[1], pins.mask_inversion_pin_l,
				pins.clock_true_pin);
			default: minterm[7] = pins.group_sel[1] ^ pins.clock_true_pin;
		endcase
		minterm[8] = xor3(pins.addr[14], pins.addr[12], pins.bank_sel[0]);
		minterm[9] = xor3(pins.group_sel[0], pins.addr[3],
			pins.mem_reset_pin_n & pins.test_enable_pin);
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		outs = PCT_OUT_RST;
		case (ORG)
			ORG_X4: begin
				for (int i = 0; i < 4; i++) begin
					outs.dq[i] = minterm[2*i] ^ minterm[2*i+1];
				end
			end
			ORG_X8: begin
				outs.dq[7:0] = minterm[7:0];
			end
			default: begin
				outs.dq[7:0] = minterm[7:0];
				outs.dq[15:8] = ~minterm[7:0];
				outs.dqs[3:2] = ~minterm[9:8];
			end
		endcase
		outs.dqs[1:0] = minterm[9:8];
	end

endmodule : pct_xor_net

// *** rtl/pct_top.sv ***
// connectivity check mode: pin sampling, mode control, output drive
`timescale 1ns/100ps
module pct_top
	import pct_pkg::*;
#(
	parameter pct_org_t ORG = ORG_X8,
	parameter logic HAS_ADDR17 = 1'b1
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic ce,
	input wire pct_pins_t pins,
	output logic [15:0] dq_o,
	output logic [15:0] dq_oe_n,
	output logic [3:0] dqs_o,
	output logic [3:0] dqs_oe_n,
	output logic continuity_check_mode,
	output logic data_reference_level_half
);

	localparam logic [15:0] DQ_LANES = (ORG == ORG_X4) ? PCT_DQ_LANES_X4 :
		(ORG == ORG_X8) ? PCT_DQ_LANES_X8 : PCT_DQ_LANES_X16;
	localparam logic [3:0] DQS_LANES = (ORG == ORG_X16) ? PCT_DQS_LANES_X16 :
		PCT_DQS_LANES_NARROW;

	typedef struct packed {
		pct_pins_t s1;
		pct_pins_t s2;
		pct_pins_t s3;
		pct_pins_t filt;
		pct_mode_t mode;
		pct_out_t out;
		logic [15:0] dq_oe_n;
		logic [3:0] dqs_oe_n;
		logic vref_half;
	} pct_state_t;

	localparam pct_state_t STATE_RST = '{
		s1: PCT_PINS_RST, s2: PCT_PINS_RST, s3: PCT_PINS_RST, filt: PCT_PINS_RST,
		mode: MODE_NORMAL, out: PCT_OUT_RST, dq_oe_n: PCT_DQ_OE_OFF,
		dqs_oe_n: PCT_DQS_OE_OFF, vref_half: 1'b0};

	pct_state_t q;
	pct_state_t d;
	pct_out_t net;
	logic drive;

	pct_xor_net #(
		.ORG(ORG),
		.HAS_ADDR17(HAS_ADDR17)
	) u_net (
		.pins(q.filt),
		.outs(net)
	);

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		d = q;
		d.s1 = pins;
		d.s2 = q.s1;
		d.s3 = q.s2;
		if (q.s2 == q.s3) begin
			d.filt = q.s3;
		end
		d.mode = q.filt.test_enable_pin ? MODE_CHECK : MODE_NORMAL;
		d.vref_half = (q.mode == MODE_CHECK);
		drive = (q.mode == MODE_CHECK) && !q.filt.cs_n;
		d.out = (q.mode == MODE_CHECK) ? net : PCT_OUT_RST;
		d.dq_oe_n = drive ? ~DQ_LANES : PCT_DQ_OE_OFF;
		d.dqs_oe_n = drive ? ~DQS_LANES : PCT_DQS_OE_OFF;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			q <= STATE_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	assign dq_o = q.out.dq;
	assign dq_oe_n = q.dq_oe_n;
	assign dqs_o = q.out.dqs;
	assign dqs_oe_n = q.dqs_oe_n;
	assign continuity_check_mode = (q.mode == MODE_CHECK);
	assign data_reference_level_half = q.vref_half;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock iff ce);
	endclocking
	default disable iff (!reset_n);

	property p_mode_enter;
		q.filt.test_enable_pin |=> continuity_check_mode;
	endproperty
	a_mode_enter: assert property (p_mode_enter) else $error("mode not entered");

	property p_mode_leave;
		!q.filt.test_enable_pin |=> !continuity_check_mode;
	endproperty
	a_mode_leave: assert property (p_mode_leave) else $error("mode not left");

	property p_normal_quiet;
		!continuity_check_mode |=> (&dq_oe_n) && (&dqs_oe_n) && (dq_o == 16'h0000);
	endproperty
	a_normal_quiet: assert property (p_normal_quiet) else $error("pins active in normal");

	property p_vref;
		data_reference_level_half == $past(continuity_check_mode);
	endproperty
	a_vref: assert property (p_vref) else $error("reference level wrong");

	property p_drive_cause;
		!dq_oe_n[0] |-> $past(continuity_check_mode) && !$past(q.filt.cs_n);
	endproperty
	a_drive_cause: assert property (p_drive_cause) else $error("driven without select");

	property p_hiz;
		continuity_check_mode && q.filt.cs_n |=> (&dq_oe_n) && (&dqs_oe_n);
	endproperty
	a_hiz: assert property (p_hiz) else $error("outputs not high impedance");

	property p_pin_latency;
		$changed(pins.cs_n) && q.filt.test_enable_pin ##1 $stable(pins.cs_n) [*4]
			|-> (q.filt.cs_n == pins.cs_n);
	endproperty
	a_pin_latency: assert property (p_pin_latency) else $error("pin latency wrong");

	property p_strobe_true;
		!dqs_oe_n[0] |-> dqs_o[0] ==
			$past(q.filt.addr[14] ^ q.filt.addr[12] ^ q.filt.bank_sel[0]);
	endproperty
	a_strobe_true: assert property (p_strobe_true) else $error("true strobe wrong");

	property p_dq0;
		(ORG != ORG_X4) && !dq_oe_n[0] |->
			dq_o[0] == $past(q.filt.addr[1] ^ q.filt.addr[6] ^ q.filt.ca_parity_input);
	endproperty
	a_dq0: assert property (p_dq0) else $error("data bit 0 wrong");

	property p_upper_inv;
		(ORG == ORG_X16) && continuity_check_mode && !dq_oe_n[8] |->
			(dq_o[15:8] == ~dq_o[7:0]) && (dqs_o[3:2] == ~dqs_o[1:0]);
	endproperty
	a_upper_inv: assert property (p_upper_inv) else $error("upper byte not inverted");

	////////////////////////////////////////////////////////////////////////////////
	// per-minterm output equations, then lane, enable and freeze checks and covers
	property p_dq1;
		(ORG != ORG_X4) && !dq_oe_n[1] |->
			dq_o[1] == $past(q.filt.addr[8] ^ q.filt.alert_n ^ q.filt.addr[9]);
	endproperty
	a_dq1: assert property (p_dq1) else $error("data bit 1 wrong");

	property p_dq2;
		(ORG != ORG_X4) && !dq_oe_n[2] |-> dq_o[2] == $past(q.filt.addr[2] ^ q.filt.addr[5]
			^ q.filt.addr[13] ^ (HAS_ADDR17 & q.filt.addr[17]));
	endproperty
	a_dq2: assert property (p_dq2) else $error("data bit 2 wrong");

	property p_dq3;
		(ORG != ORG_X4) && !dq_oe_n[3] |->
			dq_o[3] == $past(q.filt.addr[0] ^ q.filt.addr[7] ^ q.filt.addr[11]);
	endproperty
	a_dq3: assert property (p_dq3) else $error("data bit 3 wrong");

	property p_dq4;
		(ORG != ORG_X4) && !dq_oe_n[4] |-> dq_o[4] == $past(q.filt.clock_comp_pin
			^ q.filt.termination_control_pin ^ q.filt.addr[15]);
	endproperty
	a_dq4: assert property (p_dq4) else $error("data bit 4 wrong");

	property p_dq5;
		(ORG != ORG_X4) && !dq_oe_n[5] |->
			dq_o[5] == $past(q.filt.cke ^ q.filt.addr[16] ^ q.filt.addr[10]);
	endproperty
	a_dq5: assert property (p_dq5) else $error("data bit 5 wrong");

	property p_dq6;
		(ORG != ORG_X4) && !dq_oe_n[6] |->
			dq_o[6] == $past(q.filt.activate_cmd_pin ^ q.filt.addr[4] ^ q.filt.bank_sel[1]);
	endproperty
	a_dq6: assert property (p_dq6) else $error("data bit 6 wrong");

	property p_dq7;
		(ORG != ORG_X4) && !dq_oe_n[7] |-> dq_o[7] == $past(q.filt.clock_true_pin
			^ q.filt.mask_inversion_pin_l ^ ((ORG == ORG_X16) ? q.filt.mask_inversion_pin_u
			: q.filt.group_sel[1]));
	endproperty
	a_dq7: assert property (p_dq7) else $error("data bit 7 wrong");

	property p_strobe_comp;
		!dqs_oe_n[1] |-> dqs_o[1] == $past(q.filt.group_sel[0] ^ q.filt.addr[3]
			^ (q.filt.mem_reset_pin_n & q.filt.test_enable_pin));
	endproperty
	a_strobe_comp: assert property (p_strobe_comp) else $error("comp strobe wrong");

	property p_x4_pair;
		(ORG == ORG_X4) && !dq_oe_n[0] |-> dq_o[0] == $past(q.filt.addr[1] ^ q.filt.addr[6]
			^ q.filt.ca_parity_input ^ q.filt.addr[8] ^ q.filt.alert_n ^ q.filt.addr[9]);
	endproperty
	a_x4_pair: assert property (p_x4_pair) else $error("narrow pair wrong");

	property p_lanes_off;
		(&(dq_oe_n | DQ_LANES)) && (&(dqs_oe_n | DQS_LANES));
	endproperty
	a_lanes_off: assert property (p_lanes_off) else $error("unused lane driven");

	property p_unused_zero;
		((dq_o & ~DQ_LANES) == 16'h0000) && ((dqs_o & ~DQS_LANES) == 4'h0);
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused lane value");

	property p_oe_group;
		(&dq_oe_n) == (&dqs_oe_n);
	endproperty
	a_oe_group: assert property (p_oe_group) else $error("enables split");

	property p_freeze;
		@(posedge clock) !ce |=> $stable(q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");

	c_enter: cover property (!continuity_check_mode ##1 continuity_check_mode);
	c_drive: cover property (continuity_check_mode && !dq_oe_n[0]);
	c_hiz: cover property (continuity_check_mode && dq_oe_n[0]);
	c_leave: cover property (continuity_check_mode ##1 !continuity_check_mode);
	c_strobe_comp: cover property (!dqs_oe_n[1] && dqs_o[1]);

endmodule : pct_top

// *** test/pct_agent.sv ***
// board test agent model driving the device pins
`timescale 1ns/100ps
module pct_agent
	import pct_pkg::*;
(
	input wire logic test_enable_pin,
	input wire logic cs_n,
	input wire pct_pins_t pat,
	output pct_pins_t pins
);
	always_comb begin
		pins = pat;
		pins.test_enable_pin = test_enable_pin;
		pins.cs_n = cs_n;
		pins.mem_reset_pin_n = 1'b1;
	end
endmodule : pct_agent

// *** test/pct_tb_top.sv ***
// self-checking bench for the connectivity check block
`timescale 1ns/100ps
module pct_tb_top
	import pct_pkg::*;
;
	logic clock, reset_n, ce, test_enable_pin, cs_n, mode, vref;
	pct_pins_t pat, pins;
	logic [15:0] dq_o, dq_oe_n;
	logic [3:0] dqs_o, dqs_oe_n;
	int error_cnt, samples_checked;
	pct_top #(.ORG(ORG_X16), .HAS_ADDR17(1'b1)) pct_top_i (.clock(clock), .reset_n(reset_n),
		.ce(ce), .pins(pins), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dqs_o(dqs_o),
		.dqs_oe_n(dqs_oe_n), .continuity_check_mode(mode), .data_reference_level_half(vref));
	logic [15:0] dq_o8, dq_oe_n8, dq_o4, dq_oe_n4;
	logic [3:0] dqs_o8, dqs_oe_n8, dqs_o4, dqs_oe_n4;
	logic mode8, vref8, mode4, vref4;
	pct_top #(.ORG(ORG_X8), .HAS_ADDR17(1'b1)) pct_top_x8_i (.clock(clock), .reset_n(reset_n),
		.ce(ce), .pins(pins), .dq_o(dq_o8), .dq_oe_n(dq_oe_n8), .dqs_o(dqs_o8),
		.dqs_oe_n(dqs_oe_n8), .continuity_check_mode(mode8), .data_reference_level_half(vref8));
	pct_top #(.ORG(ORG_X4), .HAS_ADDR17(1'b0)) pct_top_x4_i (.clock(clock), .reset_n(reset_n),
		.ce(ce), .pins(pins), .dq_o(dq_o4), .dq_oe_n(dq_oe_n4), .dqs_o(dqs_o4),
		.dqs_oe_n(dqs_oe_n4), .continuity_check_mode(mode4), .data_reference_level_half(vref4));
	pct_agent pct_agent_i (.test_enable_pin(test_enable_pin), .cs_n(cs_n), .pat(pat), .pins(pins));
	////////////////////////////////////////////////////////////////////////
	function automatic pct_out_t exp_out(input pct_pins_t p, input pct_org_t org,
		input logic a17);
		logic [9:0] m;
		pct_out_t o;
		m[0] = p.addr[1] ^ p.addr[6] ^ p.ca_parity_input;
		m[1] = p.addr[8] ^ p.alert_n ^ p.addr[9];
		m[2] = p.addr[2] ^ p.addr[5] ^ p.addr[13] ^ (a17 & p.addr[17]);
		m[3] = p.addr[0] ^ p.addr[7] ^ p.addr[11];
		m[4] = p.clock_comp_pin ^ p.termination_control_pin ^ p.addr[15];
		m[5] = p.cke ^ p.addr[16] ^ p.addr[10];
		m[6] = p.activate_cmd_pin ^ p.addr[4] ^ p.bank_sel[1];
		m[7] = p.clock_true_pin ^ ((org == ORG_X4) ? p.group_sel[1] : (org == ORG_X8) ?
			(p.group_sel[1] ^ p.mask_inversion_pin_l) :
			(p.mask_inversion_pin_u ^ p.mask_inversion_pin_l));
		m[8] = p.addr[14] ^ p.addr[12] ^ p.bank_sel[0];
		m[9] = p.group_sel[0] ^ p.addr[3] ^ (p.mem_reset_pin_n & p.test_enable_pin);
		o = PCT_OUT_RST;
		o.dqs[1:0] = m[9:8];
		if (org == ORG_X4) begin
			o.dq[3:0] = {m[6] ^ m[7], m[4] ^ m[5], m[2] ^ m[3], m[0] ^ m[1]};
		end else begin
			o.dq[7:0] = m[7:0];
		end
		if (org == ORG_X16) begin
			o.dq[15:8] = ~m[7:0];
			o.dqs[3:2] = ~m[9:8];
		end
		return o;
	endfunction : exp_out
	task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic final_report;
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report
	task automatic apply(input logic t, input logic c, input pct_pins_t p);
		@(posedge clock);
		#1;
		test_enable_pin = t;
		cs_n = c;
		pat = p;
		repeat (7) @(posedge clock);
		#1;
	endtask : apply
	////////////////////////////////////////////////////////////////////////
	task automatic t_normal;
		apply(1'b0, 1'b0, pct_pins_t'(34'h3ffffffff));
		chk({dq_o, dqs_o}, 20'h00000);
		chk({dq_o8 | dq_o4, dqs_o8 | dqs_o4}, 20'h00000);
		chk({dq_oe_n, dqs_oe_n}, 20'hfffff);
		chk({dq_oe_n8 & dq_oe_n4, dqs_oe_n8 & dqs_oe_n4}, 20'hfffff);
		chk({18'h0, mode, vref}, 20'h00000);
		chk({16'h0, mode8, vref8, mode4, vref4}, 20'h00000);
	endtask : t_normal
	task automatic t_walk;
		apply(1'b1, 1'b1, pct_pins_t'(34'h0));
		for (int i = 0; i < 33; i++) begin
			apply(1'b1, 1'b0, pct_pins_t'(34'h1 << i));
			chk({dq_o, dqs_o}, exp_out(pins, ORG_X16, 1'b1));
			chk({dq_o8, dqs_o8}, exp_out(pins, ORG_X8, 1'b1));
			chk({dq_o4, dqs_o4}, exp_out(pins, ORG_X4, 1'b0));
			chk({dq_oe_n, dqs_oe_n}, 20'h00000);
			chk({dq_oe_n8, dqs_oe_n8}, 20'hff00c);
			chk({dq_oe_n4, dqs_oe_n4}, 20'hfff0c);
			chk({18'h0, mode, vref}, 20'h00003);
			chk({16'h0, mode8, vref8, mode4, vref4}, 20'h0000f);
		end
	endtask : t_walk
	task automatic t_latency;
		pct_out_t e1;
		apply(1'b1, 1'b0, pct_pins_t'(34'h0000aaa5));
		e1 = exp_out(pins, ORG_X16, 1'b1);
		@(posedge clock);
		#1;
		pat = pct_pins_t'(34'h00015a5a);
		repeat (PCT_OUT_LATENCY - 1) @(posedge clock);
		#1;
		chk({dq_o, dqs_o}, e1);
		@(posedge clock);
		#1;
		chk({dq_o, dqs_o}, exp_out(pins, ORG_X16, 1'b1));
	endtask : t_latency
	task automatic t_freeze;
		pct_out_t e1;
		e1 = exp_out(pins, ORG_X16, 1'b1);
		@(posedge clock);
		#1;
		ce = 1'b0;
		pat = pct_pins_t'(34'h00033cc3);
		repeat (8) @(posedge clock);
		#1;
		chk({dq_o, dqs_o}, e1);
		ce = 1'b1;
		repeat (7) @(posedge clock);
		#1;
		chk({dq_o, dqs_o}, exp_out(pins, ORG_X16, 1'b1));
	endtask : t_freeze
	task automatic t_deselect;
		apply(1'b1, 1'b1, pct_pins_t'(34'h0003c3c3));
		chk({dq_oe_n, dqs_oe_n}, 20'hfffff);
		chk({dq_oe_n8 & dq_oe_n4, dqs_oe_n8 & dqs_oe_n4}, 20'hfffff);
		chk({18'h0, mode, vref}, 20'h00003);
	endtask : t_deselect
	////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		#20000;
		error_cnt++;
		final_report();
	end
	initial begin
		reset_n = 1'b0;
		ce = 1'b1;
		test_enable_pin = 1'b0;
		cs_n = 1'b1;
		pat = pct_pins_t'(34'h0);
		repeat (4) @(posedge clock);
		#1;
		chk({dq_oe_n, dqs_oe_n}, 20'hfffff);
		reset_n = 1'b1;
		t_normal();
		t_walk();
		t_latency();
		t_freeze();
		t_deselect();
		t_normal();
		final_report();
	end
endmodule : pct_tb_top
